// ==== rtl/urp_root_port.sv ====
// Functional notes
// - power status bit reads 1 when port powered, 0 when off.
// - overcurrent detection clears the power status bit.
// - global scheme: only all-ports on/off commands change power.
// - per-port scheme with mask set: only single-port commands act.
// - per-port scheme with mask clear: only all-ports commands act.
// - power off clears connected, enabled, suspended and reset status.
// - writing 1 at bit 8 powers port; 0 does nothing.
// - without power switching the power bit always reads 1.
// - writing 1 at bit 4 starts reset; signalling while status 1.
// - reset end clears reset status; done flag sets one cycle later.
// - reset status never set while no device connected.
// - reset request on empty port sets connection change flag.
// - only a 1 at bit 4 starts reset; 0 ignored.
// - done flag sets after 10 ms pulse; cleared by writing 1.
// - writing 1 at bit 9 powers port off; 0 does nothing.
//
// Purpose: power control and reset signalling of one root hub port
// Assumes: Avalon-MM slave, one clock, inputs synchronous
// Notes:   connect, enable and suspend come from neighbouring port logic
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "urp_cfg.svh"

module urp_root_port
  import urp_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = `URP_RESET_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  input  wire logic        device_connected,
  input  wire logic        port_enabled,
  input  wire logic        port_suspended,
  input  wire logic        overcurrent,
  output logic             port_power_state,
  output logic             port_reset_active,
  output logic             usb_reset_drive,
  output logic             port_status_clear,
  output logic             irq
);

  logic                    powered;
  logic                    reset_done_flag;
  logic                    conn_change_flag;
  logic [4:0]              config_reg;
  logic [`URP_IRQ_W-1:0]   irq_status;
  logic [`URP_IRQ_W-1:0]   irq_enable;
  logic                    acked;
  logic                    wr_acc;
  logic [31:0]             wdata_m;
  logic                    timer_start;
  logic                    timer_abort;
  logic                    timer_active;
  logic                    timer_done;
  logic                    ps_write;
  logic                    cfg_write;
  logic                    single_cmd_ok;
  logic                    global_cmd_ok;
  logic                    power_on_req;
  logic                    power_off_req;
  logic                    next_powered;
  logic                    conn_chg_set;
  logic                    oc_prev;
  logic                    oc_rise;
  logic                    irq_clr_write;
  logic                    irq_en_write;
  logic                    reset_cmd;
  logic                    rst_done_clr;
  logic                    conn_chg_clr;
  logic [31:0]             status_word;

  // byte-lane mask of a write
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // register select by byte offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // ==========================================
  // bus handshake: one wait cycle, then accept
  // the wait cycle lets read data be registered before acceptance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acked <= 1'b0;
    end else begin
      acked <= (read || write) && !acked;
    end
  end

  assign waitrequest   = (read || write) && !acked;
  assign wr_acc        = write && acked;
  assign wdata_m       = writedata & lane_mask(byteenable);
  assign ps_write      = wr_acc && reg_hit(address, `URP_OFS_PORT_STATUS);
  assign cfg_write     = wr_acc && reg_hit(address, `URP_OFS_CONFIG);
  assign irq_clr_write = wr_acc && reg_hit(address, `URP_OFS_IRQ_CLEAR);
  assign irq_en_write  = wr_acc && reg_hit(address, `URP_OFS_IRQ_ENABLE);
  assign reset_cmd     = ps_write && wdata_m[`URP_BIT_RESET];
  assign rst_done_clr  = ps_write && wdata_m[`URP_BIT_RST_DONE];
  assign conn_chg_clr  = ps_write && wdata_m[`URP_BIT_CONN_CHG];

  // ==========================================
  // power command steering
  // scheme and mask select
  assign single_cmd_ok = config_reg[`URP_BIT_SCHEME] && config_reg[`URP_BIT_MASK];
  assign global_cmd_ok = !single_cmd_ok;

  assign power_on_req  = (ps_write && wdata_m[`URP_BIT_POWER_ON] && single_cmd_ok)
                      || (cfg_write && wdata_m[`URP_BIT_ALL_ON] && global_cmd_ok);
  assign power_off_req = (ps_write && wdata_m[`URP_BIT_POWER_OFF] && single_cmd_ok)
                      || (cfg_write && wdata_m[`URP_BIT_ALL_OFF] && global_cmd_ok);

  assign oc_rise = overcurrent && !oc_prev;

  always_comb begin
    next_powered = powered;
    if (power_on_req) begin
      next_powered = 1'b1;
    end
    // off wins when both commands come in one write
    if (power_off_req) begin
      next_powered = 1'b0;
    end
    if (overcurrent) begin
      next_powered = 1'b0;
    end
    if (config_reg[`URP_BIT_NO_SWITCHING]) begin
      next_powered = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      powered <= 1'b0;
      oc_prev <= 1'b0;
    end else begin
      powered <= next_powered;
      oc_prev <= overcurrent;
    end
  end

  assign port_power_state = powered;
  // clear port status on power loss
  assign port_status_clear = !powered;

  // ==========================================
  // port reset
  // start only on connected powered port
  assign timer_start = reset_cmd && device_connected
                    && powered && !timer_active;
  // power off or detach ends reset
  // a cut pulse gives no done event, so no false completion
  assign timer_abort = !powered || !device_connected;
  assign conn_chg_set = reset_cmd && !device_connected;

  urp_reset_timer #(
    .CYCLES (RESET_CYCLES)
  ) u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .start  (timer_start),
    .abort  (timer_abort),
    .active (timer_active),
    .done   (timer_done)
  );

  assign port_reset_active = timer_active;
  assign usb_reset_drive   = timer_active;

  // ==========================================
  // change flags, set wins over clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_done_flag <= 1'b0;
    end else if (timer_done) begin
      reset_done_flag <= 1'b1;
    end else if (rst_done_clr) begin
      reset_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      conn_change_flag <= 1'b0;
    end else if (conn_chg_set) begin
      conn_change_flag <= 1'b1;
    end else if (conn_chg_clr) begin
      conn_change_flag <= 1'b0;
    end
  end

  // ==========================================
  // configuration
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      config_reg <= `URP_RST_CONFIG;
    end else if (cfg_write) begin
      config_reg[`URP_BIT_SCHEME]       <= wdata_m[`URP_BIT_SCHEME];
      config_reg[`URP_BIT_MASK]         <= wdata_m[`URP_BIT_MASK];
      config_reg[`URP_BIT_NO_SWITCHING] <= wdata_m[`URP_BIT_NO_SWITCHING];
      config_reg[`URP_BIT_ALL_ON]       <= 1'b0;
      config_reg[`URP_BIT_ALL_OFF]      <= 1'b0;
    end
  end

  // ==========================================
  // interrupts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
    end else begin
      for (int i = 0; i < `URP_IRQ_W; i++) begin
        if (irq_clr_write && wdata_m[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
      if (timer_done) begin
        irq_status[`URP_IRQ_RST_DONE] <= 1'b1;
      end
      if (conn_chg_set) begin
        irq_status[`URP_IRQ_CONN_CHG] <= 1'b1;
      end
      if (oc_rise) begin
        irq_status[`URP_IRQ_OVERCURRENT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable <= `URP_RST_IRQ_ENABLE;
    end else if (irq_en_write) begin
      irq_enable <= wdata_m[`URP_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ==========================================
  // port status read word
  always_comb begin
    status_word = 32'h0;
    status_word[`URP_BIT_CONNECTED] = device_connected && powered;
    status_word[`URP_BIT_ENABLED]   = port_enabled && powered;
    status_word[`URP_BIT_SUSPENDED] = port_suspended && powered;
    status_word[`URP_BIT_RESET]     = timer_active;
    status_word[`URP_BIT_POWER_ON]  = powered || config_reg[`URP_BIT_NO_SWITCHING];
    status_word[`URP_BIT_CONN_CHG]  = conn_change_flag;
    status_word[`URP_BIT_RST_DONE]  = reset_done_flag;
  end

  // ==========================================
  // read data, registered in the wait cycle before acceptance
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0;
      response <= 2'b00;
    end else if (read && !acked) begin
      readdata <= 32'h0;
      response <= 2'b00;
      unique case (address)
        `URP_OFS_PORT_STATUS: begin
          readdata <= status_word;
        end
        `URP_OFS_CONFIG: begin
          readdata[4:0] <= config_reg;
        end
        `URP_OFS_IRQ_STATUS: begin
          readdata[`URP_IRQ_W-1:0] <= irq_status;
        end
        `URP_OFS_IRQ_ENABLE: begin
          readdata[`URP_IRQ_W-1:0] <= irq_enable;
        end
        `URP_OFS_IRQ_CLEAR: begin
          readdata <= 32'h0;
        end
        default: begin
          response <= 2'b10;
        end
      endcase
    end
  end

endmodule

// ==== rtl/urp_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: Avalon-MM word addressing at byte offsets, 25 MHz clock
// Notes:   included by the port block and its timer
`ifndef URP_CFG_SVH
`define URP_CFG_SVH

// ==========================================
// register byte offsets
`define URP_OFS_PORT_STATUS  8'h00
`define URP_OFS_CONFIG       8'h04
`define URP_OFS_IRQ_STATUS   8'h08
`define URP_OFS_IRQ_CLEAR    8'h0c
`define URP_OFS_IRQ_ENABLE   8'h10

// ==========================================
// port status field positions
`define URP_BIT_CONNECTED    0
`define URP_BIT_ENABLED      1
`define URP_BIT_SUSPENDED    2
`define URP_BIT_RESET        4
`define URP_BIT_POWER_ON     8
`define URP_BIT_POWER_OFF    9
`define URP_BIT_CONN_CHG     16
`define URP_BIT_RST_DONE     20

// config register fields
`define URP_BIT_SCHEME       0
`define URP_BIT_MASK         1
`define URP_BIT_ALL_ON       2
`define URP_BIT_ALL_OFF      3
`define URP_BIT_NO_SWITCHING 4

// irq event positions
`define URP_IRQ_RST_DONE     0
`define URP_IRQ_CONN_CHG     1
`define URP_IRQ_OVERCURRENT  2
`define URP_IRQ_W            3

// ==========================================
// reset values
`define URP_RST_CONFIG       5'h00
`define URP_RST_IRQ_ENABLE   3'h0

// ==========================================
// timing
`define URP_RESET_MS         10
`define URP_CLOCK_KHZ        25000
`define URP_RESET_CYCLES     (`URP_RESET_MS * `URP_CLOCK_KHZ)

`endif

// ==== rtl/urp_pkg.sv ====
// Purpose: types of the root port power and reset block
// Assumes: nothing
// Notes:   constants live in urp_cfg.svh
package urp_pkg;
  typedef enum logic [1:0] {
    URP_RST_IDLE  = 2'b01,
    URP_RST_DRIVE = 2'b10
  } urp_rst_state_t;
endpackage

// ==== rtl/urp_reset_timer.sv ====
// Purpose: times the port reset pulse
// Assumes: start is a one-cycle pulse while idle
// Notes:   abort drops the pulse without a done event
`timescale 1ns/100ps
`include "urp_cfg.svh"

module urp_reset_timer
  import urp_pkg::*;
#(
  parameter int unsigned CYCLES = `URP_RESET_CYCLES
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic start,
  input  wire logic abort,
  output logic      active,
  output logic      done
);

  urp_rst_state_t state;
  logic [31:0]    count;

  // ==========================================
  // pulse sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= URP_RST_IDLE;
      count <= 32'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        URP_RST_IDLE: begin
          if (start && !abort) begin
            state <= URP_RST_DRIVE;
            count <= 32'(CYCLES - 1);
          end
        end
        URP_RST_DRIVE: begin
          if (abort) begin
            state <= URP_RST_IDLE;
          end else if (count == 32'h0) begin
            state <= URP_RST_IDLE;
            done  <= 1'b1;
          end else begin
            count <= count - 32'h1;
          end
        end
        default: begin
          state <= URP_RST_IDLE;
        end
      endcase
    end
  end

  assign active = (state == URP_RST_DRIVE);

endmodule

// ==== dv/urp_root_port_properties.sv ====
// Purpose: port-level checks of the root port block
// Assumes: bound into urp_root_port, one clock domain
// Notes:   pulse length checked here and measured by the device model
`timescale 1ns/100ps
module urp_root_port_chk #(
  parameter int unsigned RESET_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  input wire logic        device_connected,
  input wire logic        port_power_state,
  input wire logic        port_reset_active,
  input wire logic        usb_reset_drive,
  input wire logic        port_status_clear
);
  logic [31:0] cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt <= 32'h0;
    else cnt <= port_reset_active ? cnt + 32'h1 : 32'h0;
  end
  a_drive_follows: assert property (
    usb_reset_drive == port_reset_active) else $error("reset drive differs");
  a_no_empty_reset: assert property (
    $rose(port_reset_active) |-> $past(device_connected)) else $error("reset on empty port");
  a_off_clears: assert property (
    !port_power_state |-> port_status_clear) else $error("status not cleared");
  a_pulse_bound: assert property (
    cnt <= RESET_CYCLES) else $error("reset pulse too long");
  a_pulse_exact: assert property (
    $fell(port_reset_active) && $past(port_power_state) && $past(device_connected)
    |-> cnt == RESET_CYCLES) else $error("reset pulse length wrong");
  a_off_stops_reset: assert property (
    !port_power_state |=> !port_reset_active) else $error("reset kept without power");
  a_first_waits: assert property (
    (read || write) && !$past(read || write) |-> waitrequest) else $error("no wait");
  a_one_wait: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("wait too long");
  a_new_waits: assert property (
    (read || write) && !waitrequest ##1 (read || write) |-> waitrequest) else $error("no wait");
  a_read_resp: assert property (read && !waitrequest && address[1:0] == 2'h0
    |-> response == ((address > 8'h10) ? 2'h2 : 2'h0)) else $error("bad response");
  a_reserved_zero: assert property (
    read && !waitrequest && address == 8'h00 |-> readdata[7:5] == 3'h0) else $error("reserved set");
  a_power_read: assert property (
    read && !waitrequest && address == 8'h00 |-> readdata[8] == $past(port_power_state))
    else $error("power bit wrong");
  a_reset_read: assert property (
    read && !waitrequest && address == 8'h00 |-> readdata[4] == $past(port_reset_active))
    else $error("reset bit wrong");
endmodule

bind urp_root_port urp_root_port_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clock(clock), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .response(response),
  .device_connected(device_connected), .port_power_state(port_power_state),
  .port_reset_active(port_reset_active), .usb_reset_drive(usb_reset_drive),
  .port_status_clear(port_status_clear));

// ==== dv/urp_usb_dev.sv ====
// Purpose: attached device and neighbouring port status
// Assumes: plugged comes from the bench
// Notes:   pulse_len is the last reset pulse in cycles
`timescale 1ns/100ps
module urp_usb_dev (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic plugged,
  input  wire logic usb_reset_drive,
  input  wire logic port_status_clear,
  output logic      device_connected,
  output logic      port_enabled,
  output logic      port_suspended,
  output int        pulse_len
);
  int run;
  assign device_connected = plugged && !port_status_clear;
  assign port_suspended = 1'b0;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      run <= 0;
      pulse_len <= 0;
      port_enabled <= 1'b0;
    end else begin
      run <= usb_reset_drive ? run + 1 : 0;
      if (!usb_reset_drive && run != 0) pulse_len <= run;
      if (!device_connected) port_enabled <= 1'b0;
      else if (!usb_reset_drive && run != 0) port_enabled <= 1'b1;
    end
  end
endmodule

// ==== dv/urp_testbench.sv ====
// Purpose: self-checking bench of the root port block
// Assumes: short reset pulse parameter
// Notes:   bus tasks end at a falling edge
`timescale 1ns/100ps
module testbench;
  localparam int unsigned RC = 20;
  logic        clock, arst_n, read, write, oc, plugged;
  logic [7:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, q, readdata;
  logic [1:0]  response;
  logic        waitrequest, dc, pe, ps, pwr, act, drv, psc, irq;
  int          plen, num_errors, checks_done;
  urp_root_port #(.RESET_CYCLES(RC)) DUT (.clock(clock), .arst_n(arst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .device_connected(dc), .port_enabled(pe),
    .port_suspended(ps), .overcurrent(oc), .port_power_state(pwr), .port_reset_active(act),
    .usb_reset_drive(drv), .port_status_clear(psc), .irq(irq));
  urp_usb_dev u_dev (.clock(clock), .arst_n(arst_n), .plugged(plugged), .usb_reset_drive(drv),
    .port_status_clear(psc), .device_connected(dc), .port_enabled(pe), .port_suspended(ps),
    .pulse_len(plen));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int  n;
    logic wt;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(negedge clock);
      wt = waitrequest;
      @(posedge clock);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clock);
    if (n == 20) chk("bus_wait", 32'h0, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic t_regs;
    rd(8'h00);
    chk("status", 32'h0, q);
    rd(8'h04);
    chk("config", 32'h0, q);
    rd(8'h10);
    chk("irq_en", 32'h0, q);
    rd(8'h14);
    chk("unmapped", 32'h2, response);
    wr(8'h00, 32'h1e0);
    rd(8'h00);
    chk("global_single", 32'h0, q);
    $display("test regs done");
  endtask
  task automatic t_modes;
    logic [31:0] m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 32'h0 : (i == 1) ? 32'h3 : 32'h1;
      wr(8'h04, m | 32'h8);
      wr(8'h00, 32'h200);
      chk("off", 32'h0, pwr);
      wr(8'h00, 32'h100);
      chk("single_on", m == 32'h3, pwr);
      rd(8'h00);
      chk("stat_pwr", m == 32'h3, q[8]);
      wr(8'h00, 32'h0);
      chk("zero_write", m == 32'h3, pwr);
      wr(8'h04, m | 32'h8);
      chk("all_off_ign", m == 32'h3, pwr);
      wr(8'h04, m | 32'h4);
      chk("all_on", 32'h1, pwr);
      wr(8'h00, 32'h200);
      chk("single_off", m != 32'h3, pwr);
    end
    $display("test modes done");
  endtask
  task automatic t_reset;
    int n;
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h100);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h0);
    chk("no_start", 32'h0, act);
    wr(8'h00, 32'h10);
    chk("started", 32'h1, drv);
    n = 0;
    while (act !== 1'b0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    repeat (2) @(negedge clock);
    chk("pulse_len", RC, plen);
    rd(8'h00);
    chk("done", 32'h00100103, q & 32'h001001ff);
    chk("irq_on", 32'h1, irq);
    wr(8'h10, 32'h0);
    chk("irq_mask", 32'h0, irq);
    wr(8'h00, 32'h00100000);
    rd(8'h00);
    chk("flag_clr", 32'h0, q[20]);
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h1);
    chk("irq_clr", 32'h0, irq);
    $display("test reset done");
  endtask
  task automatic t_empty;
    @(posedge clock);
    plugged <= 1'b0;
    wr(8'h00, 32'h10);
    chk("empty_rst", 32'h0, act);
    rd(8'h00);
    chk("conn_flag", 32'h00010000, q & 32'h00010010);
    rd(8'h08);
    chk("irq_conn", 32'h1, q[1]);
    @(posedge clock);
    plugged <= 1'b1;
    $display("test empty done");
  endtask
  task automatic t_over;
    wr(8'h00, 32'h10);
    @(posedge clock);
    oc <= 1'b1;
    repeat (3) @(negedge clock);
    chk("oc_off", 32'h0, pwr);
    chk("oc_clear", 32'h1, psc);
    chk("oc_rst", 32'h0, act);
    rd(8'h00);
    chk("oc_stat", 32'h0, q & 32'h117);
    rd(8'h08);
    chk("irq_oc", 32'h1, q[2]);
    wr(8'h04, 32'h10);
    rd(8'h00);
    chk("no_switch_rd", 32'h1, q[8]);
    chk("no_switch", 32'h1, pwr);
    @(posedge clock);
    oc <= 1'b0;
    $display("test overcurrent done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #(40 * 4000);
    num_errors++;
    print_verdict();
  end
  initial begin
    {arst_n, read, write, oc, address, writedata} = '0;
    plugged = 1'b1;
    byteenable = 4'hf;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_modes();
    t_reset();
    t_empty();
    t_over();
    print_verdict();
  end
endmodule
